// ===== rtl/gauge_slave.sv
// device end: two-wire slave with byte registers and alert response
//
// Added by the designer: register access over the two-wire bus.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// How it works
// - idle bus has both lines high
// - sda falling while scl high starts
// - sda rising while scl high stops
// - repeated start treated like start
// - master writes address, command, data
// - acknowledge own address with write
// - acknowledge command byte, load pointer
// - acknowledge data byte, store at pointer
// - more data bytes advance pointer
// - master reads via repeated start
// - command loads pointer before repeated start
// - send pointed byte msb first
// - master ack advances pointer, nack ends
// - master polls alert response address
// - answer alert address only while alerting
// - in an alert reply, lose arbitration when one sent, zero seen
// - lost arbitration: stop, keep alert, retry
// - completed alert response releases alert
// - slave only, scl input, sda low only
// - standard and fast mode rates
module gauge_slave (
	// clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_n,
	// two-wire bus
	gauge_bus_if.slave       bus,
	// measurement side
	input  wire logic [7:0]  i_status_flags,
	input  wire logic [15:0] i_voltage_result,
	input  wire logic        i_alert_event,
	// settings written over the bus
	output logic      [7:0]  o_control_settings,
	output logic      [15:0] o_accumulated_charge
);

	////////////////////////////////////////////////////////////////////
	// types and state
	typedef enum logic [2:0] {
		S_IDLE,  // waiting for a start
		S_RX,    // shifting a byte in
		S_ACK,   // holding our ack bit
		S_TX,    // shifting a byte out
		S_MACK,  // master ack bit after a sent byte
		S_WAIT   // released, until start or stop
	} st_t;
	typedef enum logic [1:0] {
		P_ADDR,  // next byte is an address
		P_CMD,   // next byte is the register pointer
		P_DATA   // next bytes are data
	} ph_t;
	typedef struct packed {
		logic [2:0]  scl_s;       // scl synchroniser
		logic [2:0]  sda_s;       // sda synchroniser
		logic        scl_f;       // filtered scl
		logic        sda_f;       // filtered sda
		st_t         st;          // byte engine state
		ph_t         ph;          // byte meaning
		logic [3:0]  cnt;         // bits moved in this byte
		logic [7:0]  sh;          // shift register
		logic [7:0]  ptr;         // register address pointer
		logic        rd;          // transfer is a read
		logic        ara;         // transfer is an alert response
		logic        sda_oe_n;    // pulls sda low while low
		logic        alert_pend;  // alert raised, not yet answered
		logic        alert_oe_n;  // alert pin drive
		logic [7:0]  ctrl;        // control settings
		logic [15:0] chg;         // accumulated charge
	} slave_t;
	slave_t r_r;    // registered state
	slave_t r_nxt;  // next state
	logic scl_rise;  // filtered scl edges and bus conditions
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	////////////////////////////////////////////////////////////////////
	// register read mux; unmapped pointers read as zero
	function automatic logic [7:0] rd_byte(
		input logic [7:0]  ptr,
		input logic [7:0]  stat,
		input logic [7:0]  ctrl,
		input logic [15:0] chg,
		input logic [15:0] volt
	);
		case (ptr)
			gauge_pkg::REG_STATUS:  rd_byte = stat;
			gauge_pkg::REG_CONTROL: rd_byte = ctrl;
			gauge_pkg::REG_CHG_HI:  rd_byte = chg[15:8];
			gauge_pkg::REG_CHG_LO:  rd_byte = chg[7:0];
			gauge_pkg::REG_VOLT_HI: rd_byte = volt[15:8];
			gauge_pkg::REG_VOLT_LO: rd_byte = volt[7:0];
			default:                rd_byte = 8'h00;
		endcase
	endfunction
	// pointer step after each data byte; wraps past 0xff
	function automatic logic [7:0] ptr_step(input logic [7:0] p);
		return p + 8'h01;
	endfunction

	////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		r_nxt = r_r;
		// three-stage synchronisers; only stages two and three are
		// compared, so a glitch shorter than two cycles is dropped
		r_nxt.scl_s = {r_r.scl_s[1:0], bus.scl};
		r_nxt.sda_s = {r_r.sda_s[1:0], bus.sda};
		if (r_r.scl_s[1] == r_r.scl_s[2]) begin
			r_nxt.scl_f = r_r.scl_s[2];
		end
		if (r_r.sda_s[1] == r_r.sda_s[2]) begin
			r_nxt.sda_f = r_r.sda_s[2];
		end
		scl_rise  = r_nxt.scl_f & ~r_r.scl_f;
		scl_fall  = ~r_nxt.scl_f & r_r.scl_f;
		// sda moving while scl stays high marks start or stop
		bus_start = r_r.scl_f & r_nxt.scl_f &
			r_r.sda_f & ~r_nxt.sda_f;
		bus_stop  = r_r.scl_f & r_nxt.scl_f &
			~r_r.sda_f & r_nxt.sda_f;
		if (bus_start) begin
			// a repeated start restarts address decode alike
			r_nxt.st       = S_RX;
			r_nxt.ph       = P_ADDR;
			r_nxt.cnt      = 4'h0;
			r_nxt.sda_oe_n = 1'b1;
		end else if (bus_stop) begin
			// bus free again, back to idle with sda released
			r_nxt.st       = S_IDLE;
			r_nxt.sda_oe_n = 1'b1;
		end else begin
			case (r_r.st)
				S_RX: begin
					if (scl_rise) begin
						// data is valid while scl is high
						r_nxt.sh  = {r_r.sh[6:0], r_nxt.sda_f};
						r_nxt.cnt = r_r.cnt + 4'h1;
					end else if (scl_fall && r_r.cnt == 4'h8) begin
						r_nxt.st       = S_ACK;
						r_nxt.sda_oe_n = 1'b0;
						case (r_r.ph)
							P_ADDR: begin
								if (r_r.sh[7:1] == gauge_pkg::OWN_ADDR) begin
									r_nxt.rd  = r_r.sh[0];
									r_nxt.ara = 1'b0;
								end else if (r_r.sh == {gauge_pkg::ARA_ADDR,
										1'b1} && r_r.alert_pend) begin
									r_nxt.rd  = 1'b1;
									r_nxt.ara = 1'b1;
								end else begin
									// not for us: stay off the bus
									r_nxt.st       = S_WAIT;
									r_nxt.sda_oe_n = 1'b1;
								end
							end
							P_CMD: begin
								r_nxt.ptr = r_r.sh;
							end
							default: begin
								// store, then step to the next register
								r_nxt.ptr = ptr_step(r_r.ptr);
								case (r_r.ptr)
									gauge_pkg::REG_CONTROL:
										r_nxt.ctrl = r_r.sh;
									gauge_pkg::REG_CHG_HI:
										r_nxt.chg[15:8] = r_r.sh;
									gauge_pkg::REG_CHG_LO:
										r_nxt.chg[7:0] = r_r.sh;
									// read-only and unmapped: dropped
									default: r_nxt.ctrl = r_r.ctrl;
								endcase
							end
						endcase
					end
				end
				S_ACK: begin
					if (scl_fall) begin
						r_nxt.cnt = 4'h0;
						if (r_r.ph == P_ADDR && r_r.rd) begin
							// load the byte and put its msb out
							r_nxt.sh = r_r.ara ? {gauge_pkg::OWN_ADDR, 1'b1} :
								rd_byte(r_r.ptr, i_status_flags, r_r.ctrl,
								r_r.chg, i_voltage_result);
							r_nxt.sda_oe_n = r_nxt.sh[7];
							r_nxt.sh       = {r_nxt.sh[6:0], 1'b0};
							r_nxt.cnt      = 4'h1;
							r_nxt.st       = S_TX;
						end else begin
							r_nxt.sda_oe_n = 1'b1;
							r_nxt.st       = S_RX;
							r_nxt.ph = (r_r.ph == P_ADDR) ? P_CMD : P_DATA;
						end
					end
				end
				S_TX: begin
					if (scl_rise && r_r.ara && r_r.sda_oe_n &&
							!r_nxt.sda_f) begin
						// another device sent a zero: back off at once,
						// alert stays pending for the next poll
						r_nxt.st       = S_WAIT;
						r_nxt.sda_oe_n = 1'b1;
					end else if (scl_fall) begin
						if (r_r.cnt == 4'h8) begin
							r_nxt.sda_oe_n = 1'b1;
							r_nxt.st       = S_MACK;
						end else begin
							// never drive high, a one is just released
							r_nxt.sda_oe_n = r_r.sh[7];
							r_nxt.sh       = {r_r.sh[6:0], 1'b0};
							r_nxt.cnt      = r_r.cnt + 4'h1;
						end
					end
				end
				S_MACK: begin
					if (scl_rise) begin
						if (r_r.ara) begin
							// address sent whole: alert answered
							r_nxt.alert_pend = 1'b0;
							r_nxt.st         = S_WAIT;
						end else if (!r_nxt.sda_f) begin
							// master wants more: next register
							r_nxt.ptr = ptr_step(r_r.ptr);
							r_nxt.st  = S_ACK;
						end else begin
							r_nxt.st = S_WAIT;
						end
					end
				end
				S_WAIT: begin
					r_nxt.sda_oe_n = 1'b1;
				end
				default: begin
					r_nxt.st       = S_IDLE;
					r_nxt.sda_oe_n = 1'b1;
				end
			endcase
		end
		// a new alert event wins over the clear above
		if (i_alert_event) begin
			r_nxt.alert_pend = 1'b1;
		end
		r_nxt.alert_oe_n = ~r_nxt.alert_pend;
	end

	////////////////////////////////////////////////////////////////////
	// state register; lines released and filters idle-high in reset
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			r_r            <= '0;
			r_r.scl_s      <= 3'h7;
			r_r.sda_s      <= 3'h7;
			r_r.scl_f      <= 1'b1;
			r_r.sda_f      <= 1'b1;
			r_r.sda_oe_n   <= 1'b1;
			r_r.alert_oe_n <= 1'b1;
		end else begin
			r_r <= r_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs, all straight from the state register
	assign bus.sda_s_oe_n       = r_r.sda_oe_n;
	assign bus.alert_oe_n       = r_r.alert_oe_n;
	assign o_control_settings   = r_r.ctrl;
	assign o_accumulated_charge = r_r.chg;
endmodule

// ===== rtl/gauge_pkg.sv
// shared constants for both ends of the gauge serial port
package gauge_pkg;
	// bus addresses (7 bit)
	localparam logic [6:0] OWN_ADDR = 7'h64;  // 1100100
	localparam logic [6:0] ARA_ADDR = 7'h0c;  // 0001100
	// device register pointer values
	localparam logic [7:0] REG_STATUS  = 8'h00;
	localparam logic [7:0] REG_CONTROL = 8'h01;
	localparam logic [7:0] REG_CHG_HI  = 8'h02;
	localparam logic [7:0] REG_CHG_LO  = 8'h03;
	localparam logic [7:0] REG_VOLT_HI = 8'h08;
	localparam logic [7:0] REG_VOLT_LO = 8'h09;
	// host apb register byte offsets
	localparam logic [7:0] HOST_CMD  = 8'h00;
	localparam logic [7:0] HOST_STAT = 8'h04;
	// host command word fields
	localparam int CMD_START = 8;   // start (or repeated start) first
	localparam int CMD_READ  = 9;   // read a byte instead of writing
	localparam int CMD_NACK  = 10;  // answer the read byte with nack
	localparam int CMD_STOP  = 11;  // stop after the byte
	// host status word fields ([7:0] holds the last byte read)
	localparam int STAT_BUSY  = 8;
	localparam int STAT_NACK  = 9;   // slave left the ack bit high
	localparam int STAT_ALERT = 10;  // alert pin is pulled low
	// serial clock timing
	localparam int CLK_HZ = 125000000;
	localparam int SCL_HZ = 400000;
	// quarter of a serial clock period, rounded up
	localparam int QTR_CYC = (CLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);
endpackage

// ===== rtl/gauge_bus_if.sv
// two-wire bus with alert line joining the host and the device ends
`timescale 1ns/100ps
interface gauge_bus_if;
	logic scl_oe_n;    // host pulls scl low while low
	logic sda_m_oe_n;  // host pulls sda low while low
	logic sda_s_oe_n;  // device pulls sda low while low
	logic alert_oe_n;  // device pulls alert low while low
	logic scl;         // wired-and levels with pull-ups
	logic sda;
	logic alert_n;
	assign scl     = scl_oe_n;
	assign sda     = sda_m_oe_n & sda_s_oe_n;
	assign alert_n = alert_oe_n;
	modport master (
		output scl_oe_n,
		output sda_m_oe_n,
		input  scl,
		input  sda,
		input  alert_n
	);
	modport slave (
		output sda_s_oe_n,
		output alert_oe_n,
		input  scl,
		input  sda
	);
endinterface

// ===== rtl/gauge_master.sv
// host end: apb-driven byte engine that masters the two-wire bus
`timescale 1ns/100ps
module gauge_master (
	// clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic      [31:0] prdata,
	output logic             pslverr,
	// two-wire bus
	gauge_bus_if.master      bus
);

	////////////////////////////////////////////////////////////////////
	// types and state

	typedef enum logic [1:0] {
		M_IDLE,   // waiting for a command, scl held as left
		M_START,  // start or repeated start
		M_BIT,    // eight data bits and the ack bit
		M_STOP    // stop condition
	} mst_t;

	typedef struct packed {
		logic [2:0]  sda_s;     // sda synchroniser
		logic [2:0]  alr_s;     // alert synchroniser
		logic        sda_f;     // filtered sda
		logic        alr_f;     // filtered alert, active low
		mst_t        st;        // sequencer state
		logic [1:0]  q;         // quarter within a bit
		logic [7:0]  cnt;       // quarter-period divider
		logic [3:0]  bitn;      // bit index, 8 is the ack bit
		logic [7:0]  sh;        // shift register
		logic        rd;        // command reads
		logic        nack;      // read byte answered with nack
		logic        stop;      // stop after byte
		logic [7:0]  rdata;     // last byte read
		logic        slv_nack;  // slave refused the last written byte
		logic        scl_oe_n;  // pulls scl low while low
		logic        sda_oe_n;  // pulls sda low while low
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} master_t;

	master_t r_r;    // registered state
	master_t r_nxt;  // next state
	logic    tick;   // one quarter of scl period elapsed

	////////////////////////////////////////////////////////////////////
	// next-state logic

	always_comb begin
		r_nxt = r_r;
		tick  = 1'b0;
		// pins from the far side pass three flops, stages 2 and 3 agree
		r_nxt.sda_s = {r_r.sda_s[1:0], bus.sda};
		r_nxt.alr_s = {r_r.alr_s[1:0], bus.alert_n};
		if (r_r.sda_s[1] == r_r.sda_s[2]) begin
			r_nxt.sda_f = r_r.sda_s[2];
		end
		if (r_r.alr_s[1] == r_r.alr_s[2]) begin
			r_nxt.alr_f = r_r.alr_s[2];
		end
		// divider runs only while a command is in flight
		if (r_r.st != M_IDLE) begin
			if (r_r.cnt == 8'(gauge_pkg::QTR_CYC - 1)) begin
				r_nxt.cnt = 8'h00;
				tick      = 1'b1;
			end else begin
				r_nxt.cnt = r_r.cnt + 8'h01;
			end
		end
		// apb: one wait state, writes take effect with pready high
		r_nxt.pready = 1'b0;
		if (psel && penable && !r_r.pready) begin
			r_nxt.pready  = 1'b1;
			r_nxt.pslverr = 1'b0;
			r_nxt.prdata  = 32'h0000_0000;
			case (paddr)
				gauge_pkg::HOST_CMD: r_nxt.prdata = 32'h0000_0000;
				gauge_pkg::HOST_STAT: begin
					r_nxt.prdata[7:0]                  = r_r.rdata;
					r_nxt.prdata[gauge_pkg::STAT_BUSY] = r_r.st != M_IDLE;
					r_nxt.prdata[gauge_pkg::STAT_NACK] = r_r.slv_nack;
					r_nxt.prdata[gauge_pkg::STAT_ALERT] = ~r_r.alr_f;
				end
				default: r_nxt.pslverr = 1'b1;
			endcase
		end else if (psel && penable && pwrite &&
				paddr == gauge_pkg::HOST_CMD && r_r.st == M_IDLE) begin
			// a command written while busy is dropped
			r_nxt.sh   = pwdata[7:0];
			r_nxt.rd   = pwdata[gauge_pkg::CMD_READ];
			r_nxt.nack = pwdata[gauge_pkg::CMD_NACK];
			r_nxt.stop = pwdata[gauge_pkg::CMD_STOP];
			r_nxt.st   = pwdata[gauge_pkg::CMD_START] ? M_START : M_BIT;
			r_nxt.q    = 2'h0;
			r_nxt.bitn = 4'h0;
			r_nxt.cnt  = 8'h00;
		end
		// bus sequencer, one step per quarter period
		if (tick) begin
			r_nxt.q = r_r.q + 2'h1;
			case (r_r.st)
				M_START: begin
					case (r_r.q)
						2'h0: begin
							r_nxt.sda_oe_n = 1'b1;
							r_nxt.scl_oe_n = 1'b0;
						end
						2'h1: r_nxt.scl_oe_n = 1'b1;
						2'h2: r_nxt.sda_oe_n = 1'b0;  // sda falls, scl high
						default: begin
							r_nxt.scl_oe_n = 1'b0;
							r_nxt.st       = M_BIT;
						end
					endcase
				end
				M_BIT: begin
					case (r_r.q)
						2'h0: begin
							// ones and read bits are released, not driven
							if (r_r.bitn == 4'h8) begin
								r_nxt.sda_oe_n = r_r.rd ? r_r.nack : 1'b1;
							end else begin
								r_nxt.sda_oe_n = r_r.rd | r_r.sh[7];
							end
						end
						2'h1: r_nxt.scl_oe_n = 1'b1;
						2'h2: begin
							if (r_r.bitn == 4'h8) begin
								if (!r_r.rd) begin
									r_nxt.slv_nack = r_r.sda_f;
								end
							end else begin
								r_nxt.sh = {r_r.sh[6:0], r_r.sda_f};
							end
						end
						default: begin
							r_nxt.scl_oe_n = 1'b0;
							if (r_r.bitn == 4'h8) begin
								r_nxt.rdata    = r_r.sh;
								r_nxt.sda_oe_n = 1'b1;
								r_nxt.st = r_r.stop ? M_STOP : M_IDLE;
							end else begin
								r_nxt.bitn = r_r.bitn + 4'h1;
							end
						end
					endcase
				end
				M_STOP: begin
					case (r_r.q)
						2'h0: r_nxt.sda_oe_n = 1'b0;
						2'h1: r_nxt.scl_oe_n = 1'b1;
						2'h2: r_nxt.sda_oe_n = 1'b1;  // sda rises, scl high
						default: r_nxt.st = M_IDLE;
					endcase
				end
				default: r_nxt.st = M_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// state register; both lines released in reset

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			r_r          <= '0;
			r_r.sda_s    <= 3'h7;
			r_r.alr_s    <= 3'h7;
			r_r.sda_f    <= 1'b1;
			r_r.alr_f    <= 1'b1;
			r_r.scl_oe_n <= 1'b1;
			r_r.sda_oe_n <= 1'b1;
		end else begin
			r_r <= r_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs, all straight from the state register

	assign bus.scl_oe_n   = r_r.scl_oe_n;
	assign bus.sda_m_oe_n = r_r.sda_oe_n;
	assign pready         = r_r.pready;
	assign prdata         = r_r.prdata;
	assign pslverr        = r_r.pslverr;

endmodule

// ===== bench/gauge_chk.sv
// assertion checker watching the two-wire bus between both ends
`timescale 1ns/100ps
module gauge_chk (
	// clock and reset
	input  wire logic i_sys_clk,
	input  wire logic i_rst_n,
	// device enables and wired levels
	input  wire logic sda_s_oe_n,
	input  wire logic alert_n,
	input  wire logic scl,
	input  wire logic sda
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);

	////////////////////////////////////////////////////////////////////
	logic [3:0] bits_r;   // bit clocks since the last start, stop or ack clock
	logic [7:0] sh_r;     // bits shifted in from the wire
	logic       first_r;  // address byte of the frame is running
	logic       own_r;    // frame addressed to the device
	logic       rd_r;     // direction bit of the address byte
	logic       alien_r;  // frame addressed to someone else
	logic       ara_r;    // frame opened with the alert address

	// frame tracker; raw scl is used, the bus is noise free here
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			bits_r  <= 4'h0;
			first_r <= 1'b0;
			own_r   <= 1'b0;
			rd_r    <= 1'b0;
			alien_r <= 1'b0;
			ara_r   <= 1'b0;
		end else if (scl && $past(scl) && $changed(sda)) begin
			// start opens an address byte, stop closes everything
			bits_r  <= 4'h0;
			first_r <= !sda;
			own_r   <= 1'b0;
			alien_r <= 1'b0;
			ara_r   <= 1'b0;
		end else if ($rose(scl) && bits_r == 4'h8) begin
			// acknowledge clock: decode a finished address byte
			bits_r  <= 4'h0;
			first_r <= 1'b0;
			if (first_r) begin
				own_r   <= sh_r[7:1] == gauge_pkg::OWN_ADDR;
				rd_r    <= sh_r[0];
				ara_r   <= sh_r[7:1] == gauge_pkg::ARA_ADDR;
				alien_r <= sh_r[7:1] != gauge_pkg::OWN_ADDR &&
					sh_r[7:1] != gauge_pkg::ARA_ADDR;
			end
		end else if ($rose(scl)) begin
			bits_r <= bits_r + 4'h1;
			sh_r   <= {sh_r[6:0], sda};
		end
	end

	////////////////////////////////////////////////////////////////////
	sequence ack_clk;
		$rose(scl) && bits_r == 4'h8;
	endsequence
	sequence addr_ack;
		ack_clk ##0 first_r;
	endsequence
	sequence stop_seq;
		scl && $past(scl) && $rose(sda);
	endsequence

	a_idle_after_reset: assert property ($rose(i_rst_n) |-> (scl && sda) [*4]) else $error("bus not idle after reset");
	a_change_scl_low: assert property ($changed(sda_s_oe_n) |-> !scl) else $error("device moved sda with scl high");
	a_stop_quiet: assert property (stop_seq |-> sda_s_oe_n [*8]) else $error("device drove sda after stop");
	a_own_ack: assert property (addr_ack ##0 (sh_r[7:1] == gauge_pkg::OWN_ADDR) |-> !sda) else $error("own address not acked");
	a_write_ack: assert property (ack_clk ##0 (!first_r && own_r && !rd_r) |-> !sda) else $error("written byte not acked");
	a_alien_quiet: assert property (alien_r |-> sda_s_oe_n) else $error("device answered a foreign frame");
	a_ara_ack: assert property (addr_ack ##0 (sh_r == {gauge_pkg::ARA_ADDR, 1'b1} && !alert_n) |-> !sda) else $error("alert address not acked");
	a_ara_quiet: assert property (addr_ack ##0 (sh_r[7:1] == gauge_pkg::ARA_ADDR && alert_n) |-> sda) else $error("alert address acked without alert");
	a_alert_release: assert property ($rose(alert_n) |-> ara_r && bits_r == 4'h0) else $error("alert released outside a reply");
endmodule

// ===== bench/gauge_serial_slave_port_tb.sv
// self-checking bench: host end drives the device end over the bus
`timescale 1ns/100ps
module gauge_serial_slave_port_tb;
	localparam int LIMIT = 90000;  // cycles; 24 bytes need about 75k
	logic        i_sys_clk;
	logic        i_rst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic [7:0]  i_status_flags;
	logic [15:0] i_voltage_result;
	logic        i_alert_event;
	logic [7:0]  o_control_settings;
	logic [15:0] o_accumulated_charge;
	int          num_errors;
	int          checks_done;
	int          cyc = 0;

	gauge_bus_if bus ();
	gauge_master gauge_master_inst (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .bus(bus));
	gauge_slave gauge_slave_inst (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
		.bus(bus), .i_status_flags(i_status_flags),
		.i_voltage_result(i_voltage_result), .i_alert_event(i_alert_event),
		.o_control_settings(o_control_settings),
		.o_accumulated_charge(o_accumulated_charge));
	gauge_chk gauge_chk_inst (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
		.sda_s_oe_n(bus.sda_s_oe_n), .alert_n(bus.alert_n),
		.scl(bus.scl), .sda(bus.sda));

	////////////////////////////////////////////////////////////////////
	// 125 MHz clock and a hang guard
	always #4 i_sys_clk = ~i_sys_clk;
	always @(posedge i_sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			num_errors++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, got);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// one apb transfer: request held until pready is seen at an edge;
	// only the cycle ceiling ends a wait that never gets an answer
	task automatic apb(input logic w, input logic [7:0] ad,
		input logic [31:0] wd, output logic [31:0] q, output logic e);
		@(posedge i_sys_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= ad;
		pwdata  <= wd;
		@(posedge i_sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge i_sys_clk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// command word: stop, nack, read, start, byte
	function automatic logic [11:0] cw(input logic s, r, k, p,
		input logic [7:0] byt);
		return {p, k, r, s, byt};
	endfunction

	// issue one bus byte, wait until idle, compare the whole status word
	task automatic step(input string nm, input logic [11:0] cmd,
		input logic al, input logic nk, input logic [7:0] byt);
		logic [31:0] st;
		logic        e;
		apb(1'b1, gauge_pkg::HOST_CMD, {20'h0, cmd}, st, e);
		chk({nm, " err"}, 32'h0, {31'h0, e});
		do begin
			apb(1'b0, gauge_pkg::HOST_STAT, 32'h0, st, e);
		end while (st[gauge_pkg::STAT_BUSY] !== 1'b0);
		chk(nm, {21'h0, al, nk, 1'b0, byt}, st);
	endtask

	////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [31:0] q;
		logic        e;
		chk("ctrl rst", 32'h0, {24'h0, o_control_settings});
		chk("chg rst", 32'h0, {16'h0, o_accumulated_charge});
		apb(1'b0, gauge_pkg::HOST_STAT, 32'h0, q, e);
		chk("stat rst", 32'h0, q & 32'h700);
		apb(1'b0, 8'h08, 32'h0, q, e);
		chk("unmapped err", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, q);
		apb(1'b0, gauge_pkg::HOST_CMD, 32'h0, q, e);
		chk("cmd rd", 32'h0, q);
	endtask

	// burst write crossing from control into the charge pair
	task automatic t_write();
		step("wr addr", cw(1, 0, 0, 0, 8'hc8), 0, 0, 8'hc8);
		step("wr ptr", cw(0, 0, 0, 0, 8'h01), 0, 0, 8'h01);
		step("wr ctrl", cw(0, 0, 0, 0, 8'hfc), 0, 0, 8'hfc);
		step("wr chg hi", cw(0, 0, 0, 0, 8'hf0), 0, 0, 8'hf0);
		step("wr chg lo", cw(0, 0, 0, 1, 8'h01), 0, 0, 8'h01);
		chk("ctrl", 32'hfc, {24'h0, o_control_settings});
		chk("chg", 32'hf001, {16'h0, o_accumulated_charge});
	endtask

	// read four bytes from the status register on
	task automatic t_read();
		step("rd addr w", cw(1, 0, 0, 0, 8'hc8), 0, 0, 8'hc8);
		step("rd ptr", cw(0, 0, 0, 0, 8'h00), 0, 0, 8'h00);
		step("rd addr r", cw(1, 0, 0, 0, 8'hc9), 0, 0, 8'hc9);
		step("rd stat", cw(0, 1, 0, 0, 8'h00), 0, 0, 8'h01);
		step("rd ctrl", cw(0, 1, 0, 0, 8'h00), 0, 0, 8'hfc);
		step("rd chg hi", cw(0, 1, 0, 0, 8'h00), 0, 0, 8'hf0);
		step("rd chg lo", cw(0, 1, 1, 1, 8'h00), 0, 0, 8'h01);
	endtask

	// two-byte read of the measured voltage, high byte first
	task automatic t_volt();
		step("v addr w", cw(1, 0, 0, 0, 8'hc8), 0, 0, 8'hc8);
		step("v ptr", cw(0, 0, 0, 0, 8'h08), 0, 0, 8'h08);
		step("v addr r", cw(1, 0, 0, 0, 8'hc9), 0, 0, 8'hc9);
		step("v hi", cw(0, 1, 0, 0, 8'h00), 0, 0, 8'hf1);
		step("v lo", cw(0, 1, 1, 1, 8'h00), 0, 0, 8'h24);
	endtask

	task automatic t_alien();
		step("alien", cw(1, 0, 0, 1, 8'ha0), 0, 1, 8'ha0);
	endtask

	// alert reply: refused, acked, lost to a zero, retried, released
	task automatic t_alert();
		step("ara idle", cw(1, 0, 0, 1, 8'h19), 0, 1, 8'h19);
		@(posedge i_sys_clk);
		i_alert_event <= 1'b1;
		@(posedge i_sys_clk);
		i_alert_event <= 1'b0;
		step("ara ack", cw(1, 0, 0, 0, 8'h19), 1, 0, 8'h19);
		step("ara lose", cw(0, 0, 0, 1, 8'h00), 1, 1, 8'h00);
		step("ara retry", cw(1, 0, 0, 0, 8'h19), 1, 0, 8'h19);
		step("ara reply", cw(0, 1, 1, 1, 8'h00), 0, 0, 8'hc9);
		step("ara after", cw(1, 0, 0, 1, 8'h19), 0, 1, 8'h19);
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		i_sys_clk        = 1'b0;
		i_rst_n          = 1'b0;
		psel             = 1'b0;
		penable          = 1'b0;
		pwrite           = 1'b0;
		paddr            = 8'h00;
		pwdata           = 32'h0;
		i_status_flags   = 8'h01;
		i_voltage_result = 16'hf124;
		i_alert_event    = 1'b0;
		num_errors       = 0;
		checks_done      = 0;
		repeat (10) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		t_reset();
		t_write();
		t_read();
		t_volt();
		t_alien();
		t_alert();
		give_verdict();
	end
endmodule
